// File: src/ptr_target_read.sv
// Target sequencer for 64-bit burst reads with a 64-bit local side
`timescale 1ns/1ps
module ptr_target_read
	import ptr_pkg::*;
#(
	parameter int NUM = NUM_BARS,
	parameter logic [NUM*ADDR_W-1:0] BASE = BAR_BASE_DFLT,
	parameter logic [NUM*ADDR_W-1:0] MASK = BAR_MASK_DFLT
) (
	input wire logic sys_clk, // Bus clock
	input wire logic nrst, // Asynchronous reset, low
	input wire logic frameN, // Cycle frame, low
	input wire logic req64N, // Wide request, low
	input wire logic irdyN, // Initiator ready, low
	input wire logic [CBE_W-1:0] cbeIn, // Command and byte enables
	input wire logic [DATA_W-1:0] adIn, // Address/data in
	output logic [DATA_W-1:0] adOut, // Read data out
	output logic adOeN, // Data drive enable, low
	output logic devselOut, // Select value
	output logic devselOeN, // Select drive enable, low
	output logic ack64Out, // Wide acknowledge value
	output logic ack64OeN, // Wide acknowledge enable, low
	output logic trdyOut, // Target ready value
	output logic trdyOeN, // Target ready enable, low
	input wire logic [SEL_W-1:0] selectSpeedSetting, // Select timing
	output logic [ADDR_W-1:0] localTargetAddr, // Address to back-end
	output logic wideXferFlag, // Wide transfer requested
	output logic [NUM-1:0] barHit, // Window chip selects
	input wire logic localReadyN, // Back-end ready, low
	output logic lowWordStrobeN, // Low half taken, low
	output logic highWordStrobeN, // High half taken, low
	input wire logic [DATA_W-1:0] localDataIn // Back-end read data
);
	logic rstSync1_ff;
	logic rstN_ff;
	ptr_state_t state_ff, nxt_state;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [CMD_W-1:0] cmd_ff, nxt_cmd;
	logic wide_ff, nxt_wide;
	logic [NUM-1:0] barHit_ff, nxt_barHit;
	logic devselOut_ff, nxt_devselOut;
	logic devselOeN_ff, nxt_devselOeN;
	logic ack64Out_ff, nxt_ack64Out;
	logic ack64OeN_ff, nxt_ack64OeN;
	logic trdyOut_ff, nxt_trdyOut;
	logic trdyOeN_ff, nxt_trdyOeN;
	logic adOeN_ff, nxt_adOeN;
	logic strobeN_ff, nxt_strobeN;
	logic xferSeen_ff, nxt_xferSeen;
	logic rdyD1_ff, nxt_rdyD1;
	logic [DATA_W-1:0] outData_ff, nxt_outData;
	logic outVld_ff, nxt_outVld;
	logic [DATA_W-1:0] spareData_ff, nxt_spareData;
	logic spareVld_ff, nxt_spareVld;
	logic [NUM-1:0] decHit;
	logic isRead;
	logic rdyNow;
	logic trdyOn;
	logic consume;
	logic wordIn;
	logic keepOut;
	logic done;

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1_ff <= 1'b0;
			rstN_ff <= 1'b0;
		end else begin
			rstSync1_ff <= 1'b1;
			rstN_ff <= rstSync1_ff;
		end
	end

	// Only memory read commands are claimed
	assign isRead = (cmd_ff == CMD_MEM_READ) || (cmd_ff == CMD_MEM_RD_MULT) ||
		(cmd_ff == CMD_MEM_RD_LINE);

	ptr_bar_decode #(
		.NUM(NUM),
		.BASE(BASE),
		.MASK(MASK)
	) u_decode (
		.addr(addr_ff),
		.enable(isRead),
		.hit(decHit)
	);

	// Handshake terms from active-low bus and back-end signals
	assign rdyNow = !localReadyN;
	assign trdyOn = !trdyOeN_ff && !trdyOut_ff;
	assign consume = trdyOn && !irdyN;
	assign wordIn = !strobeN_ff;
	assign keepOut = outVld_ff && !consume;
	// Final data phase: frame already high while the word moves
	assign done = (state_ff == ST_DATA) && consume && frameN;

	// Next-state and output computation
	always_comb begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_cmd = cmd_ff;
		nxt_wide = wide_ff;
		nxt_barHit = barHit_ff;
		nxt_devselOut = devselOut_ff;
		nxt_devselOeN = devselOeN_ff;
		nxt_ack64Out = ack64Out_ff;
		nxt_ack64OeN = ack64OeN_ff;
		nxt_trdyOut = trdyOut_ff;
		nxt_trdyOeN = trdyOeN_ff;
		nxt_adOeN = adOeN_ff;
		nxt_strobeN = 1'b1;
		nxt_xferSeen = xferSeen_ff;
		nxt_rdyD1 = rdyNow;
		nxt_outData = outData_ff;
		nxt_outVld = 1'b0;
		nxt_spareData = spareData_ff;
		nxt_spareVld = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (!frameN) begin
					// Address phase: latch address, command, width
					nxt_addr = adIn[ADDR_W-1:0];
					nxt_cmd = cbeIn[CMD_W-1:0];
					nxt_wide = !req64N;
					nxt_state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				if (|decHit) begin
					// Window hit shows in the third clock
					nxt_barHit = decHit;
					nxt_state = ST_CLAIM;
					if (selectSpeedSetting != SEL_SLOW) begin
						nxt_devselOut = 1'b0;
						nxt_devselOeN = 1'b0;
						nxt_ack64Out = !wide_ff;
						nxt_ack64OeN = 1'b0;
						nxt_trdyOut = 1'b1;
						nxt_trdyOeN = 1'b0;
					end
				end else begin
					nxt_state = ST_IGNORE;
				end
			end
			ST_CLAIM: begin
				// Slow select: claim the clock after the hit
				nxt_devselOut = 1'b0;
				nxt_devselOeN = 1'b0;
				nxt_ack64Out = !wide_ff;
				nxt_ack64OeN = 1'b0;
				nxt_trdyOut = 1'b1;
				nxt_trdyOeN = 1'b0;
				nxt_adOeN = 1'b0;
				nxt_state = ST_DATA;
			end
			ST_DATA: begin
				// First ready, then ready with irdyn, pulls a word
				if (rdyNow && (!xferSeen_ff || !irdyN)) begin
					nxt_strobeN = 1'b0;
					nxt_xferSeen = 1'b1;
				end
				// Output word moves on; a spare catches an early arrival
				if (!keepOut) begin
					if (spareVld_ff) begin
						nxt_outData = spareData_ff;
						nxt_outVld = 1'b1;
					end else begin
						nxt_outVld = wordIn;
						if (wordIn) begin
							nxt_outData = localDataIn;
						end
					end
				end else begin
					nxt_outVld = 1'b1;
				end
				if (wordIn && (keepOut || spareVld_ff)) begin
					nxt_spareData = localDataIn;
					nxt_spareVld = 1'b1;
				end else if (spareVld_ff && keepOut) begin
					nxt_spareVld = 1'b1;
				end
				// Ready held two clocks and a word to show
				nxt_trdyOut = !(rdyNow && rdyD1_ff && nxt_outVld);
				if (done) begin
					// Drive handshakes high, float data
					nxt_trdyOut = 1'b1;
					nxt_devselOut = 1'b1;
					nxt_ack64Out = 1'b1;
					nxt_adOeN = 1'b1;
					// Completion to back-end, strobes off
					nxt_barHit = '0;
					nxt_strobeN = 1'b1;
					// Prefetched words are dropped
					nxt_outVld = 1'b0;
					nxt_spareVld = 1'b0;
					nxt_xferSeen = 1'b0;
					nxt_state = ST_TURN;
				end
			end
			ST_TURN: begin
				// Stop driving the handshakes
				nxt_devselOeN = 1'b1;
				nxt_ack64OeN = 1'b1;
				nxt_trdyOeN = 1'b1;
				nxt_state = ST_IDLE;
			end
			ST_IGNORE: begin
				if (frameN && irdyN) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge sys_clk or negedge rstN_ff) begin
		if (!rstN_ff) begin
			state_ff <= ST_IDLE;
			addr_ff <= ADDR_RST;
			cmd_ff <= CMD_RST;
			wide_ff <= 1'b0;
			barHit_ff <= '0;
			devselOut_ff <= 1'b1;
			devselOeN_ff <= 1'b1;
			ack64Out_ff <= 1'b1;
			ack64OeN_ff <= 1'b1;
			trdyOut_ff <= 1'b1;
			trdyOeN_ff <= 1'b1;
			adOeN_ff <= 1'b1;
			strobeN_ff <= 1'b1;
			xferSeen_ff <= 1'b0;
			rdyD1_ff <= 1'b0;
			outData_ff <= DATA_RST;
			outVld_ff <= 1'b0;
			spareData_ff <= DATA_RST;
			spareVld_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			cmd_ff <= nxt_cmd;
			wide_ff <= nxt_wide;
			barHit_ff <= nxt_barHit;
			devselOut_ff <= nxt_devselOut;
			devselOeN_ff <= nxt_devselOeN;
			ack64Out_ff <= nxt_ack64Out;
			ack64OeN_ff <= nxt_ack64OeN;
			trdyOut_ff <= nxt_trdyOut;
			trdyOeN_ff <= nxt_trdyOeN;
			adOeN_ff <= nxt_adOeN;
			strobeN_ff <= nxt_strobeN;
			xferSeen_ff <= nxt_xferSeen;
			rdyD1_ff <= nxt_rdyD1;
			outData_ff <= nxt_outData;
			outVld_ff <= nxt_outVld;
			spareData_ff <= nxt_spareData;
			spareVld_ff <= nxt_spareVld;
		end
	end

	// Outputs straight from flip-flops
	assign adOut = outData_ff;
	assign adOeN = adOeN_ff;
	assign devselOut = devselOut_ff;
	assign devselOeN = devselOeN_ff;
	assign ack64Out = ack64Out_ff;
	assign ack64OeN = ack64OeN_ff;
	assign trdyOut = trdyOut_ff;
	assign trdyOeN = trdyOeN_ff;
	assign localTargetAddr = addr_ff;
	assign wideXferFlag = wide_ff;
	assign barHit = barHit_ff;
	// High half strobe only for wide transfers
	assign lowWordStrobeN = strobeN_ff;
	assign highWordStrobeN = strobeN_ff || !wide_ff;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstN_ff);

	a_addr_present: assert property (
		(state_ff == ST_IDLE) && !frameN |=>
		(localTargetAddr == $past(adIn[ADDR_W-1:0])) && (wideXferFlag == !$past(req64N)))
		else $error("address or wide flag not presented");
	a_hit_timing: assert property (
		(state_ff == ST_DECODE) && (|decHit) |=> barHit == $past(decHit))
		else $error("window hit not asserted in third clock");
	a_slow_select: assert property (
		(selectSpeedSetting == SEL_SLOW) && $rose(|barHit) |->
		devselOeN ##1 (!devselOut && !devselOeN && (ack64Out == !wideXferFlag)))
		else $error("slow select not asserted after hit");
	a_strobe_first: assert property (
		(state_ff == ST_DATA) && rdyNow && !xferSeen_ff && !done |=>
		!lowWordStrobeN && (highWordStrobeN == !wideXferFlag))
		else $error("strobes missing after first ready");
	a_strobe_keep: assert property (
		(state_ff == ST_DATA) && rdyNow && !irdyN && !done |=> !lowWordStrobeN)
		else $error("strobe dropped with irdy and ready");
	a_trdy_cause: assert property (
		!trdyOut && !trdyOeN |-> $past(rdyNow) && $past(rdyNow, 2) && !adOeN)
		else $error("trdy without two ready clocks or data drive");
	a_data_word: assert property (
		(state_ff == ST_DATA) && wordIn && !outVld_ff && !spareVld_ff |=>
		adOut == $past(localDataIn))
		else $error("back-end word not placed on data lines");
	a_finish: assert property (
		done |=> trdyOut && devselOut && ack64Out && adOeN && !trdyOeN)
		else $error("handshakes not deasserted after last transfer");
	a_complete: assert property (
		done |=> (barHit == '0) && lowWordStrobeN && highWordStrobeN)
		else $error("hits or strobes not cleared at completion");
	a_release: assert property (
		done |=> ##1 trdyOeN && devselOeN && ack64OeN)
		else $error("handshakes not released in idle clock");
	a_no_extra: assert property (
		done |=> trdyOut [*3])
		else $error("prefetched word reached the bus");
endmodule

// File: src/ptr_pkg.sv
// Constants, state codes and contract for the 64-bit target burst read
// Contract
// - Second clock: present address, wide flag
// - Third clock: window hit on address match
// - Slow select: devseln, ack64n after hit
// - Both strobes one clock after first ready (high strobe only on wide transfers)
// - Ready two clocks: trdyn and first word
// - Irdyn and ready before: keep strobes
// - Ready held two clocks: keep trdyn, data
// - After last transfer: deassert, float ad
// - Same clock: clear hits, drop strobes
// - Idle clock: release devseln, ack64n, trdyn
// - Prefetched extra word is discarded
package ptr_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int CBE_W = 8;
	localparam int CMD_W = 4;
	localparam int SEL_W = 2;
	localparam int NUM_BARS = 2;
	// Read commands the target claims
	localparam logic [CMD_W-1:0] CMD_MEM_READ = 4'h6;
	localparam logic [CMD_W-1:0] CMD_MEM_RD_MULT = 4'hC;
	localparam logic [CMD_W-1:0] CMD_MEM_RD_LINE = 4'hE;
	// Select timing settings
	localparam logic [SEL_W-1:0] SEL_FAST = 2'h0;
	localparam logic [SEL_W-1:0] SEL_MEDIUM = 2'h1;
	localparam logic [SEL_W-1:0] SEL_SLOW = 2'h2;
	// Default address windows: base and compare mask
	localparam logic [NUM_BARS*ADDR_W-1:0] BAR_BASE_DFLT = 64'h2000_0000_1000_0000;
	localparam logic [NUM_BARS*ADDR_W-1:0] BAR_MASK_DFLT = 64'hFFFF_0000_FFFF_0000;
	// Reset values
	localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0;
	localparam logic [CMD_W-1:0] CMD_RST = 4'h0;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DECODE = 6'h02,
		ST_CLAIM = 6'h04,
		ST_DATA = 6'h08,
		ST_TURN = 6'h10,
		ST_IGNORE = 6'h20
	} ptr_state_t;
endpackage

// File: src/ptr_bar_decode.sv
// Address window comparator producing one hit bit per window
`timescale 1ns/1ps
module ptr_bar_decode
	import ptr_pkg::*;
#(
	parameter int NUM = NUM_BARS,
	parameter logic [NUM*ADDR_W-1:0] BASE = BAR_BASE_DFLT,
	parameter logic [NUM*ADDR_W-1:0] MASK = BAR_MASK_DFLT
) (
	input wire logic [ADDR_W-1:0] addr, // Captured address
	input wire logic enable, // Command qualifies
	output logic [NUM-1:0] hit // One bit per window
);
	genvar gi;
	// One masked compare per window
	generate
		for (gi = 0; gi < NUM; gi++) begin : g_win
			assign hit[gi] = enable &&
				((addr & MASK[gi*ADDR_W +: ADDR_W]) ==
				(BASE[gi*ADDR_W +: ADDR_W] & MASK[gi*ADDR_W +: ADDR_W]));
		end
	endgenerate
endmodule

// File: verif/ptr_backend_model.sv
// Back-end model that hands read words to the target on each strobe
`timescale 1ns/1ps
module ptr_backend_model
	import ptr_pkg::*;
(
	input wire logic sys_clk, // Bus clock
	input wire logic [NUM_BARS-1:0] barHit, // Window selects
	input wire logic lowWordStrobeN, // Word taken, low
	input wire logic [ADDR_W-1:0] localTargetAddr, // Burst address
	input wire logic stallEn, // Allow ready gaps
	output logic localReadyN, // Ready, low
	output logic [DATA_W-1:0] localDataIn // Read word
);
	int cnt = 0;
	logic [DATA_W-1:0] word;
	logic stalled = 1'b0; // Ready already dropped in this burst
	logic drop; // Ready gap chosen for this clock
	initial localReadyN = 1'b1;
	// Word k of the burst; outside strobe cycles the inverse, so stale data never matches
	assign word = {localTargetAddr + ADDR_W'(cnt), 32'h5A00_0000 | 32'(cnt)};
	assign localDataIn = lowWordStrobeN ? ~word : word;
	// Ready from the clock after the hit; each gap parks one more word in the target,
	// which holds a single spare, so ready drops at most once a burst; next word per strobe
	always @(posedge sys_clk) begin
		drop = stallEn && !stalled && ($urandom_range(3) == 0);
		localReadyN <= !(barHit != '0 && !drop);
		if (barHit == '0) begin
			cnt <= 0;
			stalled <= 1'b0;
		end else begin
			if (drop)
				stalled <= 1'b1;
			if (!lowWordStrobeN)
				cnt <= cnt + 1;
		end
	end
endmodule

// File: verif/ptr_target_read_tb.sv
// Self-checking bench for the 64-bit target burst read sequencer
`timescale 1ns/1ps
module ptr_target_read_tb;
	import ptr_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic frameN = 1'b1;
	logic req64N = 1'b1;
	logic irdyN = 1'b1;
	logic stallEn = 1'b0;
	logic readyPrev = 1'b1;
	logic [CBE_W-1:0] cbeIn = '1;
	logic [DATA_W-1:0] adIn = '0;
	logic [SEL_W-1:0] sel = SEL_FAST;
	logic [DATA_W-1:0] adOut, localDataIn;
	logic adOeN, devselOut, devselOeN, ack64Out, ack64OeN, trdyOut, trdyOeN;
	logic [ADDR_W-1:0] localTargetAddr;
	logic wideXferFlag, localReadyN, lowWordStrobeN, highWordStrobeN;
	logic [NUM_BARS-1:0] barHit;
	logic [CMD_W-1:0] cmds [3] = '{CMD_MEM_READ, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;

	ptr_target_read dut (.sys_clk(sys_clk), .nrst(nrst), .frameN(frameN), .req64N(req64N),
		.irdyN(irdyN), .cbeIn(cbeIn), .adIn(adIn), .adOut(adOut), .adOeN(adOeN),
		.devselOut(devselOut), .devselOeN(devselOeN), .ack64Out(ack64Out),
		.ack64OeN(ack64OeN), .trdyOut(trdyOut), .trdyOeN(trdyOeN),
		.selectSpeedSetting(sel), .localTargetAddr(localTargetAddr),
		.wideXferFlag(wideXferFlag), .barHit(barHit), .localReadyN(localReadyN),
		.lowWordStrobeN(lowWordStrobeN), .highWordStrobeN(highWordStrobeN),
		.localDataIn(localDataIn));

	ptr_backend_model backEnd (.sys_clk(sys_clk), .barHit(barHit),
		.lowWordStrobeN(lowWordStrobeN), .localTargetAddr(localTargetAddr),
		.stallEn(stallEn), .localReadyN(localReadyN), .localDataIn(localDataIn));

	// Clock generation
	always #25 sys_clk = ~sys_clk;

	task automatic check(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Word k that the back-end offers for a burst at address a
	function automatic logic [DATA_W-1:0] expWord(logic [ADDR_W-1:0] a, int k);
		return {a + ADDR_W'(k), 32'h5A00_0000 | 32'(k)};
	endfunction

	// One read burst of n words as bus master; hit < 0 means the target must stay silent
	task automatic burst(logic [ADDR_W-1:0] a, logic [CMD_W-1:0] cmd, logic wide, int n,
		int hit, logic [SEL_W-1:0] s, logic st);
		int k, c, dly;
		logic claim;
		logic [DATA_W-1:0] mask;
		k = 0;
		claim = hit >= 0;
		dly = $urandom_range(2);
		mask = wide ? '1 : 64'h0000_0000_FFFF_FFFF; // Upper half meaningless
		@(posedge sys_clk);
		sel <= s;
		stallEn <= st;
		frameN <= 1'b0;
		req64N <= !wide;
		adIn <= {32'hFFFF_FFFF, a};
		cbeIn <= {4'hF, cmd};
		for (c = 1; c < (claim ? 60 : 8) && k < n; c++) begin
			@(posedge sys_clk);
			adIn <= ~adIn; // Floated lines show a changing pattern
			cbeIn <= 8'h00;
			irdyN <= c <= dly;
			frameN <= c > dly && k == n - 1;
			req64N <= !wide || (c > dly && k == n - 1);
			#1;
			if (c == 1 && claim)
				check("addrWide", {31'h0, wide, a}, {31'h0, wideXferFlag, localTargetAddr});
			if (c == 2)
				check("barHit", claim ? 64'(1 << hit) : 64'h0, 64'(barHit));
			if (c == 2)
				check("earlySelectOeN", 64'(!claim || s == SEL_SLOW), 64'(devselOeN));
			if (c == 3 && claim)
				check("claim", 64'(!wide), 64'({devselOeN, devselOut, ack64OeN, adOeN, ack64Out}));
			if (!claim)
				check("silentOeN", 64'h7, 64'({devselOeN, trdyOeN, adOeN}));
			if (!trdyOut && !trdyOeN && !irdyN) begin
				check("adOut", expWord(a, k) & mask, adOut & mask);
				k++;
			end
		end
		if (claim)
			check("words", 64'(n), 64'(k));
		@(posedge sys_clk);
		frameN <= 1'b1;
		req64N <= 1'b1;
		irdyN <= 1'b1;
		cbeIn <= '1;
		#1;
		check("endValues", 64'h3F,
			64'({devselOut, trdyOut, ack64Out, adOeN, lowWordStrobeN, barHit == '0}));
		@(posedge sys_clk);
		#1;
		check("releaseOeN", 64'h7, 64'({devselOeN, trdyOeN, ack64OeN}));
	endtask

	// Strobe only after ready in the cycle before; high strobe follows the wide flag
	always @(negedge sys_clk) begin
		if (nrst && !lowWordStrobeN) begin
			check("readyBeforeStrobe", 64'h0, 64'(readyPrev));
			check("highWordStrobeN", 64'(!wideXferFlag), 64'(highWordStrobeN));
		end
		readyPrev <= localReadyN;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("Error timeout expected finish seen running");
			test_done();
		end
	end

	// Main sequence: every select setting and command, random lengths, stalls, refusals
	initial begin
		int i, b;
		void'($urandom(39679));
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (i = 0; i < 16; i++) begin
			b = $urandom_range(1);
			burst(32'((b + 1) << 28) | ($urandom & 32'h0000_FFF8), cmds[i % 3],
				1'($urandom_range(1)), 1 + $urandom_range(3), b, 2'(i), i >= 8);
			$display("Test %0d done", i);
		end
		burst(32'h1000_0040, 4'h7, 1'b1, 1, -1, SEL_FAST, 1'b0);
		$display("Test write refused done");
		burst(32'h3000_0000, CMD_MEM_READ, 1'b1, 1, -1, SEL_SLOW, 1'b0);
		$display("Test miss done");
		test_done();
	end
endmodule
